/* File: rtl/jrx_term_link_cfg.sv */
// termination calibration, termination config and general receiver control registers,
// plus the local link-parameter checksum engine
// assumes the serial port logic presents byte accesses synchronous to clk_sys_i
module jrx_term_link_cfg
	import jrx_pkg::*;
(
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic reset_n_i,
	// register port
	input wire logic [11:0] reg_addr_i,
	input wire logic reg_wr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_rd_i,
	output logic [7:0] reg_rdata_o,
	output logic reg_rvalid_o,
	// lane phy control
	output logic term_cal_trigger_b_o,
	output logic [7:0] term_config_b_first_o,
	output logic [7:0] term_config_b_second_o,
	// receiver control
	output logic checksum_mode_o,
	output logic link_dual_o,
	output logic link_page_o,
	// computed checksums
	output logic [7:0] computed_checksum_l0_o,
	output logic [7:0] computed_checksum_l1_o,
	output logic checksum_valid_o
);

	// ----------------------------------------------------------------
	// reset release
	// ----------------------------------------------------------------
	logic rst_meta_r, rst_n;
	always_ff @(posedge clk_sys_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			rst_meta_r <= 1'b0;
			rst_n <= 1'b0;
		end
		else
		begin
			rst_meta_r <= 1'b1;
			rst_n <= rst_meta_r;
		end
	end

	// ----------------------------------------------------------------
	// decode and register file
	// ----------------------------------------------------------------
	logic sel_cal, sel_cfg1, sel_cfg2, sel_gctl, sel_lcfg;
	logic cal_r, cal_nxt, cal_pulse_r, cal_pulse_nxt;
	logic [7:0] cfg1_r, cfg1_nxt, cfg2_r, cfg2_nxt, gctl_r, gctl_nxt;
	logic mem_we;
	logic [MEM_AW-1:0] mem_waddr, mem_raddr;
	logic [7:0] mem_rdata, reg_val;
	logic host_mem_rd;

	// address decode
	always_comb
	begin
		sel_cal = 1'b0;
		sel_cfg1 = 1'b0;
		sel_cfg2 = 1'b0;
		sel_gctl = 1'b0;
		sel_lcfg = 1'b0;
		if (reg_addr_i == ADDR_TERM_CAL_B)
			sel_cal = 1'b1;
		else if (reg_addr_i == ADDR_TERM_CFG_B1)
			sel_cfg1 = 1'b1;
		else if (reg_addr_i == ADDR_TERM_CFG_B2)
			sel_cfg2 = 1'b1;
		else if (reg_addr_i == ADDR_GEN_CTRL)
			sel_gctl = 1'b1;
		else if (reg_addr_i >= ADDR_LCFG_FIRST && reg_addr_i <= ADDR_LCFG_LAST)
			sel_lcfg = 1'b1;
	end

	// register next values
	always_comb
	begin
		cal_nxt = cal_r;
		cfg1_nxt = cfg1_r;
		cfg2_nxt = cfg2_r;
		gctl_nxt = gctl_r;
		cal_pulse_nxt = 1'b0;
		if (reg_wr_i && sel_cal)
		begin
			cal_nxt = reg_wdata_i[BIT_TERM_CAL];
			cal_pulse_nxt = reg_wdata_i[BIT_TERM_CAL] && !cal_r;
		end
		if (reg_wr_i && sel_cfg1)
			cfg1_nxt = reg_wdata_i;
		if (reg_wr_i && sel_cfg2)
			cfg2_nxt = reg_wdata_i;
		if (reg_wr_i && sel_gctl)
			gctl_nxt = reg_wdata_i & MASK_GEN_CTRL;
	end

	always_ff @(posedge clk_sys_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cal_r <= 1'b0;
			cal_pulse_r <= 1'b0;
			cfg1_r <= RST_TERM_CFG_B1;
			cfg2_r <= RST_TERM_CFG_B2;
			gctl_r <= 8'h00;
		end
		else
		begin
			cal_r <= cal_nxt;
			cal_pulse_r <= cal_pulse_nxt;
			cfg1_r <= cfg1_nxt;
			cfg2_r <= cfg2_nxt;
			gctl_r <= gctl_nxt;
		end
	end

	assign term_cal_trigger_b_o = cal_pulse_r;
	assign term_config_b_first_o = cfg1_r;
	assign term_config_b_second_o = cfg2_r;
	assign checksum_mode_o = gctl_r[BIT_CSUM_MODE];
	assign link_dual_o = gctl_r[BIT_LINK_DUAL];
	assign link_page_o = gctl_r[BIT_LINK_PAGE];

	// ----------------------------------------------------------------
	// link config memory, paged by link
	// ----------------------------------------------------------------
	logic [3:0] eng_idx_r, eng_idx_nxt;
	logic eng_link_r, eng_link_nxt;
	jrx_state_t state_r, state_nxt;
	logic issue;

	// byte 0 is shared, the rest follow the page bit
	always_comb
	begin
		host_mem_rd = reg_rd_i && sel_lcfg;
		mem_we = reg_wr_i && sel_lcfg;
		if (reg_addr_i == ADDR_LCFG_FIRST)
			mem_waddr = '0;
		else
			mem_waddr = {gctl_r[BIT_LINK_PAGE], reg_addr_i[3:0]};
		if (host_mem_rd)
			mem_raddr = mem_waddr;
		else if (eng_idx_r == 4'h0)
			mem_raddr = '0;
		else
			mem_raddr = {eng_link_r, eng_idx_r};
	end

	jrx_cfg_mem u_mem (
		.clk_sys_i(clk_sys_i),
		.rst_n_i(rst_n),
		.wr_en_i(mem_we),
		.wr_addr_i(mem_waddr),
		.wr_data_i(reg_wdata_i),
		.rd_addr_i(mem_raddr),
		.rd_data_o(mem_rdata)
	);

	// ----------------------------------------------------------------
	// read path, two cycles from request to data
	// ----------------------------------------------------------------
	logic rd_d1_r, rd_mem_r;
	logic [7:0] rd_val_r;

	// register values with reserved bits at zero
	always_comb
	begin
		reg_val = 8'h00;
		if (sel_cal)
			reg_val = {7'h00, cal_r};
		else if (sel_cfg1)
			reg_val = cfg1_r;
		else if (sel_cfg2)
			reg_val = cfg2_r;
		else if (sel_gctl)
			reg_val = gctl_r;
	end

	always_ff @(posedge clk_sys_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rd_d1_r <= 1'b0;
			rd_mem_r <= 1'b0;
			rd_val_r <= 8'h00;
			reg_rvalid_o <= 1'b0;
			reg_rdata_o <= 8'h00;
		end
		else
		begin
			rd_d1_r <= reg_rd_i;
			rd_mem_r <= host_mem_rd;
			rd_val_r <= reg_val;
			reg_rvalid_o <= rd_d1_r;
			reg_rdata_o <= rd_mem_r ? mem_rdata : rd_val_r;
		end
	end

	// ----------------------------------------------------------------
	// checksum engine: walks bytes 0..10 of link 0 then link 1
	// ----------------------------------------------------------------
	logic dirty_r, dirty_nxt, pend_r, pend_nxt, pend_link_r, pend_link_nxt;
	logic [3:0] pend_idx_r, pend_idx_nxt;
	logic [7:0] acc_r, acc_nxt, sum0_nxt, sum1_nxt, term, total;
	logic valid_nxt, start, dirty_set;

	// contribution of one packed byte in field mode
	function automatic logic [7:0] field_sum(input logic [3:0] idx, input logic [7:0] b);
		logic [7:0] s;
		s = 8'h00;
		case (idx)
			4'h1: s = {4'h0, b[7:4]} + {4'h0, b[3:0]};
			4'h2: s = {7'h00, b[6]} + {7'h00, b[5]} + {3'h0, b[4:0]};
			4'h3: s = {7'h00, b[7]} + {3'h0, b[4:0]};
			4'h5: s = {3'h0, b[4:0]};
			4'h7: s = {6'h00, b[7:6]} + {3'h0, b[4:0]};
			4'h8: s = {5'h00, b[7:5]} + {3'h0, b[4:0]};
			4'h9: s = {5'h00, b[7:5]} + {3'h0, b[4:0]};
			4'ha: s = {7'h00, b[7]} + {3'h0, b[4:0]};
			default: s = b;
		endcase
		return s;
	endfunction

	always_comb
	begin
		dirty_set = mem_we || (reg_wr_i && sel_gctl);
		start = (state_r == ST_IDLE) && dirty_r;
		dirty_nxt = dirty_set || (dirty_r && !start); // set wins over clear
		issue = (state_r == ST_RUN) && !host_mem_rd; // host reads take the port
		state_nxt = state_r;
		eng_idx_nxt = eng_idx_r;
		eng_link_nxt = eng_link_r;
		case (state_r)
			ST_IDLE:
			begin
				if (start)
				begin
					state_nxt = ST_RUN;
					eng_idx_nxt = 4'h0;
					eng_link_nxt = 1'b0;
				end
			end
			ST_RUN:
			begin
				if (issue)
				begin
					if (eng_idx_r == LCFG_IDX_LAST)
					begin
						eng_idx_nxt = 4'h0;
						eng_link_nxt = 1'b1;
						if (eng_link_r)
							state_nxt = ST_IDLE;
					end
					else
						eng_idx_nxt = eng_idx_r + 4'h1;
				end
			end
			default: state_nxt = ST_IDLE;
		endcase
		pend_nxt = issue;
		pend_idx_nxt = eng_idx_r;
		pend_link_nxt = eng_link_r;
		// both methods wrap modulo 256 in the 8-bit adder
		term = gctl_r[BIT_CSUM_MODE] ? mem_rdata : field_sum(pend_idx_r, mem_rdata);
		total = acc_r + term;
		acc_nxt = acc_r;
		sum0_nxt = computed_checksum_l0_o;
		sum1_nxt = computed_checksum_l1_o;
		valid_nxt = checksum_valid_o && !dirty_set;
		if (pend_r)
		begin
			acc_nxt = total;
			if (pend_idx_r == LCFG_IDX_LAST)
			begin
				acc_nxt = 8'h00;
				if (pend_link_r)
				begin
					sum1_nxt = total;
					valid_nxt = !dirty_r && !dirty_set;
				end
				else
					sum0_nxt = total;
			end
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_r <= ST_IDLE;
			dirty_r <= 1'b1;
			eng_idx_r <= 4'h0;
			eng_link_r <= 1'b0;
			pend_r <= 1'b0;
			pend_idx_r <= 4'h0;
			pend_link_r <= 1'b0;
			acc_r <= 8'h00;
			computed_checksum_l0_o <= 8'h00;
			computed_checksum_l1_o <= 8'h00;
			checksum_valid_o <= 1'b0;
		end
		else
		begin
			state_r <= state_nxt;
			dirty_r <= dirty_nxt;
			eng_idx_r <= eng_idx_nxt;
			eng_link_r <= eng_link_nxt;
			pend_r <= pend_nxt;
			pend_idx_r <= pend_idx_nxt;
			pend_link_r <= pend_link_nxt;
			acc_r <= acc_nxt;
			computed_checksum_l0_o <= sum0_nxt;
			computed_checksum_l1_o <= sum1_nxt;
			checksum_valid_o <= valid_nxt;
		end
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!rst_n);

	chk_cal_edge_pulse: assert property (
		reg_wr_i && sel_cal && reg_wdata_i[0] && !cal_r |=> term_cal_trigger_b_o)
		else $error("cal trigger missing after rising write");
	chk_cal_pulse_cause: assert property (
		term_cal_trigger_b_o |-> $past(cal_r) == 1'b0 && cal_r && !$past(term_cal_trigger_b_o))
		else $error("cal trigger without rising edge");
	chk_cfg_first_write: assert property (
		reg_wr_i && sel_cfg1 |=> term_config_b_first_o == $past(reg_wdata_i))
		else $error("first term config not written");
	chk_cfg_second_write: assert property (
		reg_wr_i && sel_cfg2 |=> term_config_b_second_o == $past(reg_wdata_i))
		else $error("second term config not written");
	chk_mode_bits_follow: assert property (
		reg_wr_i && sel_gctl |=> checksum_mode_o == $past(reg_wdata_i[BIT_CSUM_MODE])
			&& link_dual_o == $past(reg_wdata_i[BIT_LINK_DUAL])
			&& link_page_o == $past(reg_wdata_i[BIT_LINK_PAGE]))
		else $error("general control bits not taken");
	chk_engine_start: assert property (
		state_r == ST_IDLE && dirty_r |=> state_r == ST_RUN && !pend_r)
		else $error("checksum engine did not start");
	chk_engine_walk: assert property (
		$rose(state_r == ST_RUN) |-> ##[22:300] state_r == ST_IDLE)
		else $error("checksum walk length wrong");
	chk_page_route: assert property (
		mem_we && reg_addr_i != ADDR_LCFG_FIRST |-> mem_waddr[4] == link_page_o)
		else $error("paged write went to wrong link");
	chk_reserved_zero: assert property (
		$past(reg_rd_i, 2) && $past(reg_addr_i, 2) == ADDR_GEN_CTRL
			|-> reg_rvalid_o && (reg_rdata_o & ~MASK_GEN_CTRL) == 8'h00)
		else $error("reserved bits read nonzero");

	cov_cal_pulse: cover property (term_cal_trigger_b_o);
	cov_sum_done: cover property ($rose(checksum_valid_o));
	cov_dual_page1: cover property (link_dual_o && link_page_o && mem_we);
	cov_mode_packed: cover property (checksum_mode_o && $rose(checksum_valid_o));

endmodule // jrx_term_link_cfg

/* File: include/jrx_pkg.sv */
// package for the receiver termination and link configuration slice
// assumes one device clock and a byte-wide register port fed by the serial port logic
package jrx_pkg;

	// ----------------------------------------------------------------
	// register offsets
	// ----------------------------------------------------------------
	localparam logic [11:0] ADDR_TERM_CAL_B = 12'h2ae; // lane_term_cal_group_b
	localparam logic [11:0] ADDR_TERM_CFG_B1 = 12'h2b1; // lane_term_config_b_first
	localparam logic [11:0] ADDR_TERM_CFG_B2 = 12'h2b2; // lane_term_config_b_second
	localparam logic [11:0] ADDR_GEN_CTRL = 12'h300; // receiver_general_control
	localparam logic [11:0] ADDR_LCFG_FIRST = 12'h400; // packed link config, shared byte
	localparam logic [11:0] ADDR_LCFG_LAST = 12'h40a; // last packed link config byte

	// ----------------------------------------------------------------
	// field positions and reset values
	// ----------------------------------------------------------------
	localparam int BIT_TERM_CAL = 0;
	localparam int BIT_CSUM_MODE = 6;
	localparam int BIT_LINK_DUAL = 3;
	localparam int BIT_LINK_PAGE = 2;
	localparam logic [7:0] RST_TERM_CFG_B1 = 8'hc3;
	localparam logic [7:0] RST_TERM_CFG_B2 = 8'h93;
	localparam logic [7:0] MASK_GEN_CTRL = 8'h4c; // writable bits of general control

	// ----------------------------------------------------------------
	// checksum engine
	// ----------------------------------------------------------------
	localparam logic [3:0] LCFG_IDX_LAST = 4'ha; // bytes 0..10 per link
	localparam int MEM_AW = 5; // {link, byte index}
	localparam int MEM_DEPTH = 32;

	typedef enum logic [1:0]
	{
		ST_IDLE = 2'b01,
		ST_RUN = 2'b10
	} jrx_state_t;

endpackage

/* File: rtl/jrx_cfg_mem.sv */
// small byte memory holding the packed link configuration of both links
// assumes one clock; read data come out of a register one cycle after the address
module jrx_cfg_mem
	import jrx_pkg::*;
(
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	// write port
	input wire logic wr_en_i,
	input wire logic [MEM_AW-1:0] wr_addr_i,
	input wire logic [7:0] wr_data_i,
	// read port
	input wire logic [MEM_AW-1:0] rd_addr_i,
	output logic [7:0] rd_data_o
);

	logic [7:0] mem_r [MEM_DEPTH];

	// ----------------------------------------------------------------
	// storage, one generate entry per byte
	// ----------------------------------------------------------------
	for (genvar g = 0; g < MEM_DEPTH; g++)
	begin : g_byte
		always_ff @(posedge clk_sys_i or negedge rst_n_i)
		begin
			if (!rst_n_i)
				mem_r[g] <= 8'h00;
			else if (wr_en_i && (wr_addr_i == MEM_AW'(g)))
				mem_r[g] <= wr_data_i;
		end
	end

	// registered read
	always_ff @(posedge clk_sys_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			rd_data_o <= 8'h00;
		else
			rd_data_o <= mem_r[rd_addr_i];
	end

endmodule // jrx_cfg_mem

/* File: bench/jrx_phy_model.sv */
// behavioural lane phy group two-five: counts calibration requests
// assumes slice outputs are settled by the falling clock edge
module jrx_phy_model
(
	// clock
	input wire logic clk_sys_i,
	// control from the register slice
	input wire logic cal_trigger_i,
	input wire logic [7:0] cfg_first_i,
	input wire logic [7:0] cfg_second_i,
	// observation
	output logic [7:0] cal_count_o,
	output logic [15:0] cfg_seen_o
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [7:0] cnt_r = 8'h00;
	logic [15:0] seen_r = 16'h0000;

	// observation ports follow the model state, one driver each
	assign cal_count_o = cnt_r;
	assign cfg_seen_o = seen_r;

	// one calibration per pulse, termination setup latched as the phys use it
	always @(negedge clk_sys_i)
	begin
		if (cal_trigger_i === 1'b1)
		begin
			cnt_r <= cnt_r + 8'h01;
			seen_r <= {cfg_first_i, cfg_second_i};
		end
	end
endmodule // jrx_phy_model

/* File: bench/jrx_term_link_cfg_tb_top.sv */
// self-checking bench for the termination and link configuration slice
// assumes reads answer two cycles after the strobe edge
module jrx_term_link_cfg_tb_top
	import jrx_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	// ------------------------------------------------------------
	// signals
	// ------------------------------------------------------------
	logic clk_sys_i, reset_n_i, reg_wr_i, reg_rd_i;
	logic [11:0] reg_addr_i;
	logic [7:0] reg_wdata_i, reg_rdata_o, cfg1, cfg2, ck0, ck1, cal_count;
	logic reg_rvalid_o, trig, mode, dual, page, cvalid;
	logic [15:0] cfg_seen;
	logic [7:0] lb [2][11];
	logic [7:0] exp_q [$];
	int fails, compares;

	jrx_term_link_cfg uut (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
		.reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i),
		.reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o),
		.term_cal_trigger_b_o(trig), .term_config_b_first_o(cfg1),
		.term_config_b_second_o(cfg2), .checksum_mode_o(mode), .link_dual_o(dual),
		.link_page_o(page), .computed_checksum_l0_o(ck0), .computed_checksum_l1_o(ck1),
		.checksum_valid_o(cvalid));

	jrx_phy_model phy (.clk_sys_i(clk_sys_i), .cal_trigger_i(trig), .cfg_first_i(cfg1),
		.cfg_second_i(cfg2), .cal_count_o(cal_count), .cfg_seen_o(cfg_seen));

	// 40 mhz clock
	always #12.5 clk_sys_i = ~clk_sys_i;

	// ------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------
	task automatic tally_and_finish();
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp)
		begin
			fails++;
			$display("MISMATCH at %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		@(negedge clk_sys_i);
		reg_addr_i = a;
		reg_wdata_i = d;
		reg_wr_i = 1'b1;
		@(negedge clk_sys_i);
		reg_wr_i = 1'b0;
	endtask

	task automatic rd(input logic [11:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		@(negedge clk_sys_i);
		reg_addr_i = a;
		reg_rd_i = 1'b1;
		@(negedge clk_sys_i);
		reg_rd_i = 1'b0;
	endtask

	task automatic wait_valid();
		int n;
		n = 0;
		repeat (3) @(negedge clk_sys_i);
		while (cvalid !== 1'b1 && n < 200)
		begin
			@(negedge clk_sys_i);
			n++;
		end
		if (cvalid !== 1'b1)
		begin
			fails++;
			tally_and_finish();
		end
	endtask

	// oldest expected read value, or a marker when none is pending
	function automatic logic [15:0] exp_head();
		return (exp_q.size() > 0) ? {8'h00, exp_q.pop_front()} : 16'hffff;
	endfunction

	function automatic logic [7:0] sum_bytes(input int k);
		logic [7:0] s;
		s = 8'h00;
		for (int i = 0; i < 11; i++)
			s += lb[k][i];
		return s;
	endfunction

	function automatic logic [7:0] sum_fields(input int k);
		logic [7:0] s;
		s = lb[k][0] + lb[k][4] + lb[k][6] + lb[k][1][7:4] + lb[k][1][3:0];
		s += lb[k][2][6] + lb[k][2][5] + lb[k][2][4:0] + lb[k][3][7] + lb[k][3][4:0];
		s += lb[k][5][4:0] + lb[k][7][7:6] + lb[k][7][4:0] + lb[k][8][7:5] + lb[k][8][4:0];
		s += lb[k][9][7:5] + lb[k][9][4:0] + lb[k][10][7] + lb[k][10][4:0];
		return s;
	endfunction

	// read answers are matched against the oldest expectation
	always @(negedge clk_sys_i)
	begin
		if (reg_rvalid_o === 1'b1)
			check({8'h00, reg_rdata_o}, exp_head());
	end

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial
	begin
		clk_sys_i = 1'b0;
		reset_n_i = 1'b0;
		reg_wr_i = 1'b0;
		reg_rd_i = 1'b0;
		reg_addr_i = 12'h000;
		reg_wdata_i = 8'h00;
		void'($urandom(32'hd0c12920));
		repeat (6) @(negedge clk_sys_i);
		reset_n_i = 1'b1;
		repeat (3) @(negedge clk_sys_i);
		// reset values and an unmapped place
		rd(ADDR_TERM_CAL_B, 8'h00);
		rd(ADDR_TERM_CFG_B1, RST_TERM_CFG_B1);
		rd(ADDR_TERM_CFG_B2, RST_TERM_CFG_B2);
		rd(ADDR_GEN_CTRL, 8'h00);
		rd(12'h123, 8'h00);
		// termination setup, then rising edges only calibrate
		wr(ADDR_TERM_CFG_B1, 8'hb7);
		wr(ADDR_TERM_CFG_B2, 8'h87);
		wr(ADDR_TERM_CAL_B, 8'hff);
		wr(ADDR_TERM_CAL_B, 8'h01);
		rd(ADDR_TERM_CAL_B, 8'h01);
		wr(ADDR_TERM_CAL_B, 8'h00);
		wr(ADDR_TERM_CAL_B, 8'h01);
		repeat (3) @(negedge clk_sys_i);
		check({8'h00, cal_count}, 16'h0002);
		check(cfg_seen, 16'hb787);
		// control bits, reserved positions dropped
		wr(ADDR_GEN_CTRL, 8'hff);
		rd(ADDR_GEN_CTRL, MASK_GEN_CTRL);
		check({13'h0000, mode, dual, page}, 16'h0007);
		// packed config per link, byte zero shared
		for (int k = 0; k < 2; k++)
		begin
			wr(ADDR_GEN_CTRL, {4'h0, 1'b1, k[0], 2'b00});
			for (int i = 0; i < 11; i++)
			begin
				lb[k][i] = (k == 1 && i == 0) ? lb[0][0] : 8'($urandom);
				if (k == 0 || i > 0)
					wr(ADDR_LCFG_FIRST + 12'(i), lb[k][i]);
			end
		end
		for (int k = 0; k < 2; k++)
		begin
			wr(ADDR_GEN_CTRL, {5'h00, k[0], 2'b00});
			for (int i = 0; i < 11; i++)
				rd(ADDR_LCFG_FIRST + 12'(i), lb[k][i]);
		end
		// field sum in single link, packed sum in dual link
		for (int m = 0; m < 2; m++)
		begin
			wr(ADDR_GEN_CTRL, {1'b0, m[0], 2'b00, m[0], 3'b000});
			wait_valid();
			check({15'h0000, dual}, {15'h0000, m[0]});
			check({8'h00, ck0}, {8'h00, m ? sum_bytes(0) : sum_fields(0)});
			check({8'h00, ck1}, {8'h00, m ? sum_bytes(1) : sum_fields(1)});
		end
		// every read must have answered
		for (int n = 0; n < 20 && exp_q.size() > 0; n++)
			@(negedge clk_sys_i);
		check(16'(exp_q.size()), 16'h0000);
		tally_and_finish();
	end
endmodule // jrx_term_link_cfg_tb_top
